// ===== hdl/doc_pkg.sv
// Shared constants and types for the dual converter output control block
package doc_pkg;
    // Register byte offsets
    localparam logic [7:0] DOC_RECOV_OFS = 8'h00;
    localparam logic [7:0] DOC_STATUS_OFS = 8'h04;
    localparam logic [7:0] DOC_COUNT_OFS = 8'h08;
    // Status field positions
    localparam int DOC_ST_READY_MODE = 0;
    localparam int DOC_ST_TWOS = 1;
    localparam int DOC_ST_POWER_DOWN = 2;
    localparam int DOC_ST_RECOVERING = 3;
    localparam int DOC_ST_RUNNING = 4;
    localparam int DOC_ST_SEL_LSB = 8;
    // Sample width and format flip mask
    localparam int DOC_SAMPLE_W = 12;
    localparam logic [11:0] DOC_MSB_MASK = 12'h800;
    // Recovery after power down, printed time and derived count
    localparam int DOC_CLK_MHZ = 200;
    localparam int DOC_RECOV_NS = 10000;
    localparam int DOC_RECOV_CYC = (DOC_RECOV_NS * DOC_CLK_MHZ + 999) / 1000;
    localparam logic [15:0] DOC_RECOV_RST = 16'(DOC_RECOV_CYC);
    // AXI response codes
    localparam logic [1:0] DOC_RESP_OKAY = 2'h0;
    localparam logic [1:0] DOC_RESP_SLVERR = 2'h2;
    // Three-level select pin encoding
    typedef enum logic [1:0] {
        DOC_LVL_LOW = 2'h0,
        DOC_LVL_HIGH = 2'h1,
        DOC_LVL_MID = 2'h2
    } doc_level_t;
    // Conversion state
    typedef enum logic [1:0] {ST_RUN, ST_DOWN, ST_RECOVER} doc_state_t;
endpackage : doc_pkg

// ===== hdl/doc_axil_slave.sv
// AXI4-Lite slave front end that turns bus traffic into register strobes
`timescale 1ns/1ps
module doc_axil_slave import doc_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic reg_wr_pulse,
    output logic [7:0] reg_wr_addr,
    output logic [31:0] reg_wr_data,
    output logic [3:0] reg_wr_strb,
    input wire logic reg_wr_err,
    output logic [7:0] reg_rd_addr,
    input wire logic [31:0] reg_rd_data,
    input wire logic reg_rd_err
);
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // Handshake readies and register strobes
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign reg_wr_pulse = aw_held_r && w_held_r && !bvalid_r;
    assign reg_wr_addr = awaddr_r;
    assign reg_wr_data = wdata_r;
    assign reg_wr_strb = wstrb_r;
    assign reg_rd_addr = s_axi_araddr;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // Next state of both channels; address and data may come in either order
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (reg_wr_pulse) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = reg_wr_err ? DOC_RESP_SLVERR : DOC_RESP_OKAY;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = reg_rd_err ? 32'h0 : reg_rd_data;
            rresp_nxt = reg_rd_err ? DOC_RESP_SLVERR : DOC_RESP_OKAY;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // Channel registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= DOC_RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= DOC_RESP_OKAY;
            rdata_r <= 32'h0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end
endmodule : doc_axil_slave

// ===== hdl/doc_output_ctrl.sv
// Output control of a dual 12-bit converter: format, enables, ready strobe, power down
// Summary of operation
// - Three-level select decodes both sample format and shared pin functions.
// - Mid level: channel B pin drives ready strobe, channel A pin picks format.
// - In ready mode both sample buses stay driven; no output enables.
// - Select low gives offset binary, select high gives two's complement.
// - Select at logic level: shared pins are active-low per-channel bus enables.
// - Power down high stops conversion.
// - During power down outputs are undefined and pipeline contents lost.
// - After power down, the ready strobe and sample count are withheld for a programmable recovery interval; the data buses still update.
// - Each channel word is valid only while enable and power down are low.
// - Two's complement is offset binary with the top bit inverted.
// - Every clock produces one sample per channel.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module doc_output_ctrl import doc_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] format_or_ready_select,
    input wire logic chan_a_enable_or_format,
    input wire logic chan_b_enable_or_ready_in,
    output logic chan_b_enable_or_ready_out,
    output logic chan_b_enable_or_ready_oe_b,
    input wire logic power_down_in,
    input wire logic [11:0] chan_a_raw,
    input wire logic [11:0] chan_b_raw,
    output logic [11:0] chan_a_data,
    output logic chan_a_data_oe_b,
    output logic [11:0] chan_b_data,
    output logic chan_b_data_oe_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic ready_mode, fmt_twos, a_enabled, b_enabled;
    logic [11:0] fmt_mask;
    doc_state_t state_r, state_nxt;
    logic [15:0] recov_r, recov_nxt, wait_r, wait_nxt;
    logic [31:0] count_r, count_nxt;
    logic [11:0] a_data_r, a_data_nxt, b_data_r, b_data_nxt;
    logic strobe_r, strobe_nxt;
    logic reg_wr_pulse, reg_wr_err, reg_rd_err;
    logic [7:0] reg_wr_addr, reg_rd_addr;
    logic [31:0] reg_wr_data, reg_rd_data;
    logic [3:0] reg_wr_strb;
    logic converting;

    // Mode decode straight from the static pins
    assign ready_mode = (format_or_ready_select == DOC_LVL_MID);
    assign fmt_twos = ready_mode ? chan_a_enable_or_format
                                 : (format_or_ready_select == DOC_LVL_HIGH);
    assign a_enabled = ready_mode || !chan_a_enable_or_format;
    assign b_enabled = ready_mode || !chan_b_enable_or_ready_in;
    assign fmt_mask = fmt_twos ? DOC_MSB_MASK : 12'h000;
    assign converting = (state_r == ST_RUN) && !power_down_in;

    // Pin drivers; output enables are active low
    assign chan_a_data = a_data_r;
    assign chan_b_data = b_data_r;
    assign chan_a_data_oe_b = !a_enabled;
    assign chan_b_data_oe_b = !b_enabled;
    assign chan_b_enable_or_ready_out = strobe_r;
    assign chan_b_enable_or_ready_oe_b = !ready_mode;

    // Power down and recovery sequencing
    always_comb begin
        state_nxt = state_r;
        wait_nxt = wait_r;
        case (state_r)
            ST_RUN: begin
                if (power_down_in) begin
                    state_nxt = ST_DOWN;
                end
            end
            ST_DOWN: begin
                if (!power_down_in) begin
                    state_nxt = (recov_r == 16'h0) ? ST_RUN : ST_RECOVER;
                    wait_nxt = recov_r;
                end
            end
            ST_RECOVER: begin
                if (power_down_in) begin
                    state_nxt = ST_DOWN;
                end else if (wait_r <= 16'h1) begin
                    state_nxt = ST_RUN;
                    wait_nxt = 16'h0;
                end else begin
                    wait_nxt = wait_r - 16'h1;
                end
            end
            default: begin
                state_nxt = ST_DOWN;
            end
        endcase
    end

    // Sample path: one word per channel per clock
    always_comb begin
        a_data_nxt = (chan_a_raw ^ fmt_mask);
        b_data_nxt = (chan_b_raw ^ fmt_mask);
        strobe_nxt = converting;
        count_nxt = converting ? count_r + 32'h1 : count_r;
        if (power_down_in) begin
            a_data_nxt = 12'h000;
            b_data_nxt = 12'h000;
        end
    end

    // Register write decode
    always_comb begin
        recov_nxt = recov_r;
        reg_wr_err = 1'b0;
        if (reg_wr_addr == DOC_RECOV_OFS) begin
            if (reg_wr_strb[0]) begin
                recov_nxt[7:0] = reg_wr_data[7:0];
            end
            if (reg_wr_strb[1]) begin
                recov_nxt[15:8] = reg_wr_data[15:8];
            end
        end else if (reg_wr_addr == DOC_STATUS_OFS || reg_wr_addr == DOC_COUNT_OFS) begin
            reg_wr_err = 1'b0;
        end else begin
            reg_wr_err = 1'b1;
        end
        if (!reg_wr_pulse) begin
            recov_nxt = recov_r;
        end
    end

    // Register read decode
    always_comb begin
        reg_rd_data = 32'h0;
        reg_rd_err = 1'b0;
        if (reg_rd_addr == DOC_RECOV_OFS) begin
            reg_rd_data = {16'h0, recov_r};
        end else if (reg_rd_addr == DOC_STATUS_OFS) begin
            reg_rd_data[DOC_ST_READY_MODE] = ready_mode;
            reg_rd_data[DOC_ST_TWOS] = fmt_twos;
            reg_rd_data[DOC_ST_POWER_DOWN] = power_down_in;
            reg_rd_data[DOC_ST_RECOVERING] = (state_r == ST_RECOVER);
            reg_rd_data[DOC_ST_RUNNING] = (state_r == ST_RUN);
            reg_rd_data[DOC_ST_SEL_LSB +: 2] = format_or_ready_select;
        end else if (reg_rd_addr == DOC_COUNT_OFS) begin
            reg_rd_data = count_r;
        end else begin
            reg_rd_err = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= ST_DOWN;
            wait_r <= 16'h0;
            recov_r <= DOC_RECOV_RST;
            count_r <= 32'h0;
            a_data_r <= 12'h000;
            b_data_r <= 12'h000;
            strobe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            recov_r <= recov_nxt;
            count_r <= count_nxt;
            a_data_r <= a_data_nxt;
            b_data_r <= b_data_nxt;
            strobe_r <= strobe_nxt;
        end
    end

    // Bus front end
    doc_axil_slave u_axil (
        .clk(clk),
        .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .reg_wr_pulse(reg_wr_pulse),
        .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data),
        .reg_wr_strb(reg_wr_strb),
        .reg_wr_err(reg_wr_err),
        .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data),
        .reg_rd_err(reg_rd_err)
    );

    // Checks on the output behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_decode_modes: assert property ((format_or_ready_select == DOC_LVL_MID) |-> ready_mode && !fmt_mask[11] == !chan_a_enable_or_format)
        else $error("Select decode wrong");
    a_offset_binary: assert property (!power_down_in && format_or_ready_select == DOC_LVL_LOW |=> chan_a_data == $past(chan_a_raw))
        else $error("Offset binary word wrong");
    a_twos_format: assert property (!power_down_in && format_or_ready_select == DOC_LVL_HIGH |=> chan_a_data == ($past(chan_a_raw) ^ 12'h800))
        else $error("Two's complement word wrong");
    a_ready_format: assert property (!power_down_in && ready_mode && chan_a_enable_or_format |=> chan_b_data == ($past(chan_b_raw) ^ 12'h800))
        else $error("Ready mode format wrong");
    a_ready_drive: assert property (ready_mode |-> !chan_a_data_oe_b && !chan_b_data_oe_b && !chan_b_enable_or_ready_oe_b)
        else $error("Bus not driven in ready mode");
    a_enable_pins: assert property (!ready_mode |-> chan_a_data_oe_b == chan_a_enable_or_format && chan_b_data_oe_b == chan_b_enable_or_ready_in && chan_b_enable_or_ready_oe_b)
        else $error("Output enable mapping wrong");
    a_down_stops: assert property (power_down_in |=> !strobe_r && count_r == $past(count_r) && chan_a_data == 12'h000)
        else $error("Conversion ran during power down");
    // Exit edge, three recovery cycles and the first running edge all show no strobe
    a_recover_wait: assert property ($fell(power_down_in) && recov_r == 16'h3 && $past(state_r) == ST_DOWN |-> !strobe_r [*5] ##1 strobe_r)
        else $error("Recovery interval wrong");
    a_sample_rate: assert property (converting |=> strobe_r && count_r == $past(count_r) + 32'h1)
        else $error("Sample not produced");
    c_ready_mode: cover property (ready_mode && strobe_r ##1 strobe_r);
    c_power_cycle: cover property (state_r == ST_DOWN ##1 state_r == ST_RECOVER);
    c_twos_enable: cover property (format_or_ready_select == DOC_LVL_HIGH && !chan_a_data_oe_b);
    c_bus_write: cover property (reg_wr_pulse && reg_wr_addr == DOC_RECOV_OFS);
endmodule : doc_output_ctrl

// ===== tb/doc_capture_model.sv
// Capture logic model that latches both sample buses on the ready strobe
`timescale 1ns/1ps
module doc_capture_model import doc_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ready_pin,
    input wire logic power_down_in,
    input wire logic [11:0] bus_a,
    input wire logic [11:0] bus_b,
    output logic [11:0] cap_a,
    output logic [11:0] cap_b,
    output logic [15:0] cap_cnt
);
    logic settle;

    // Both words are taken on one strobe edge; power down and the first strobe after it are dropped
    always @(posedge clk) begin
        if (!rst_b) begin
            cap_a <= 12'h000;
            cap_b <= 12'h000;
            cap_cnt <= 16'h0000;
            settle <= 1'b0;
        end else if (power_down_in === 1'b1) begin
            settle <= 1'b1;
        end else if (ready_pin === 1'b1) begin
            if (settle) begin
                settle <= 1'b0;
            end else begin
                cap_a <= bus_a;
                cap_b <= bus_b;
                cap_cnt <= cap_cnt + 16'h0001;
            end
        end
    end
endmodule : doc_capture_model

// ===== tb/test_dual_adc_output_control.sv
// Self-checking bench for the dual converter output control block
`timescale 1ns/1ps
module test_dual_adc_output_control import doc_pkg::*;;
    logic clk, rst_b, chan_a_enable_or_format, chan_b_enable_or_ready_in, chan_b_enable_or_ready_out;
    logic chan_b_enable_or_ready_oe_b, power_down_in, chan_a_data_oe_b, chan_b_data_oe_b, b_drive;
    logic [1:0] format_or_ready_select, s_axi_bresp, s_axi_rresp;
    logic [11:0] chan_a_raw, chan_b_raw, chan_a_data, chan_b_data, cap_a, cap_b;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] cap_cnt;
    int error_cnt, total_checks;

    // Shared pin level: the block drives it in ready mode, the board otherwise
    assign chan_b_enable_or_ready_in = chan_b_enable_or_ready_oe_b ? b_drive : chan_b_enable_or_ready_out;

    doc_output_ctrl uut (.clk, .rst_b, .format_or_ready_select, .chan_a_enable_or_format,
        .chan_b_enable_or_ready_in, .chan_b_enable_or_ready_out, .chan_b_enable_or_ready_oe_b,
        .power_down_in, .chan_a_raw, .chan_b_raw, .chan_a_data, .chan_a_data_oe_b, .chan_b_data,
        .chan_b_data_oe_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    doc_capture_model capture (.clk, .rst_b, .ready_pin(chan_b_enable_or_ready_in), .power_down_in,
        .bus_a(chan_a_data), .bus_b(chan_b_data), .cap_a, .cap_b, .cap_cnt);

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task final_report();
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report

    // Handshakes are sampled before the edge and released right after it
    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : axi_write

    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : axi_read

    // No strobe until the default recovery span after reset has run out
    task t_first_recovery();
        int n;
        n = 0;
        while (chan_b_enable_or_ready_out !== 1'b1 && n < 2100) begin
            step(1);
            n++;
        end
        chk(32'(n >= 2000 && n <= 2010), 32'h1);
    endtask : t_first_recovery

    // Recovery register, status and an unmapped word
    task t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(DOC_RECOV_OFS, d, r);
        chk(d, 32'h000007d0);
        axi_write(DOC_RECOV_OFS, 32'h00000003, r);
        chk(r, DOC_RESP_OKAY);
        axi_read(DOC_RECOV_OFS, d, r);
        chk(d, 32'h00000003);
        axi_read(8'h0c, d, r);
        chk(d, 32'h0);
        chk(32'(r), 32'(DOC_RESP_SLVERR));
        axi_read(DOC_STATUS_OFS, d, r);
        chk({d[9:8], d[DOC_ST_READY_MODE]}, {DOC_LVL_MID, 1'b1});
    endtask : t_regs

    // Ready mode: format from channel A pin, strobe on channel B pin, buses always driven
    task t_ready_mode();
        @(posedge clk);
        chan_a_enable_or_format <= 1'b0;
        b_drive <= 1'b1;
        chan_a_raw <= 12'h123;
        chan_b_raw <= 12'habc;
        step(3);
        chk({chan_a_data, chan_b_data}, {12'h123, 12'habc});
        chk({chan_a_data_oe_b, chan_b_data_oe_b}, 2'b00);
        chk({chan_b_enable_or_ready_oe_b, chan_b_enable_or_ready_out}, 2'b01);
        chk({cap_a, cap_b}, {12'h123, 12'habc});
        @(posedge clk);
        chan_a_enable_or_format <= 1'b1;
        chan_a_raw <= 12'h001;
        @(posedge clk);
        chan_a_raw <= 12'h002;
        #1;
        chk(chan_a_data, 12'h801);
        step(1);
        chk({chan_a_data, chan_b_data}, {12'h802, 12'h2bc});
    endtask : t_ready_mode

    // Logic levels: select picks the format, shared pins enable their own bus
    task t_enable_mode();
        logic [1:0] codes [3];
        codes = '{DOC_LVL_LOW, DOC_LVL_HIGH, 2'h3};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            format_or_ready_select <= codes[i];
            chan_a_enable_or_format <= 1'b0;
            b_drive <= 1'b1;
            chan_a_raw <= 12'h000;
            chan_b_raw <= 12'hfff;
            step(2);
            chk({chan_a_data, chan_b_data}, (codes[i] == DOC_LVL_HIGH) ? 24'h8007ff : 24'h000fff);
            chk({chan_a_data_oe_b, chan_b_data_oe_b}, 2'b01);
            chk(chan_b_enable_or_ready_oe_b, 1'b1);
        end
        @(posedge clk);
        chan_a_enable_or_format <= 1'b1;
        b_drive <= 1'b0;
        step(1);
        chk({chan_a_data_oe_b, chan_b_data_oe_b}, 2'b10);
        @(posedge clk);
        format_or_ready_select <= DOC_LVL_MID;
        chan_a_enable_or_format <= 1'b0;
    endtask : t_enable_mode

    // Power down stops conversion; strobe returns only after the recovery span
    task t_power_down();
        logic [31:0] c0, c1;
        logic [1:0] r;
        logic [15:0] k;
        int n;
        @(posedge clk);
        power_down_in <= 1'b1;
        chan_a_raw <= 12'h5a5;
        step(2);
        k = cap_cnt;
        chk({chan_a_data, chan_b_enable_or_ready_out}, 13'h0);
        axi_read(DOC_COUNT_OFS, c0, r);
        step(4);
        axi_read(DOC_COUNT_OFS, c1, r);
        chk(c1, c0);
        axi_read(DOC_STATUS_OFS, c0, r);
        chk(c0[DOC_ST_POWER_DOWN], 1'b1);
        chk(cap_cnt, k);
        @(posedge clk);
        power_down_in <= 1'b0;
        step(2);
        chk(chan_b_enable_or_ready_out, 1'b0);
        n = 0;
        while (chan_b_enable_or_ready_out !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        chk(chan_b_enable_or_ready_out, 1'b1);
        step(3);
        chk(cap_a, 12'h5a5);
    endtask : t_power_down

    // Main sequence
    initial begin
        error_cnt = 0;
        total_checks = 0;
        rst_b = 1'b0;
        format_or_ready_select = DOC_LVL_MID;
        chan_a_enable_or_format = 1'b0;
        b_drive = 1'b1;
        power_down_in = 1'b0;
        chan_a_raw = 12'h000;
        chan_b_raw = 12'h000;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_first_recovery();
        t_regs();
        t_ready_mode();
        t_enable_mode();
        t_power_down();
        final_report();
    end

    // Watchdog well beyond the expected run of about 2100 cycles
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
endmodule : test_dual_adc_output_control
